// ==== eepc_pkg.sv ====
// shared constants and types for the eeprom program/erase controller
package eepc_pkg;
   // apb byte addresses
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_ADDR = 12'h800;
   localparam logic [11:0] NVCFG_ADDR = 12'h804;
   localparam logic [11:0] SHADOW_ADDR = 12'h808;
   localparam int ARR_MSB = 11;
   // array geometry
   localparam int ARR_BYTES = 512;
   localparam int IDX_W = 9;
   localparam int BLK_LSB = 7;
   localparam int NUM_BLK = 4;
   localparam logic [8:0] SEC_LO = 9'h0F0;
   localparam logic [8:0] SEC_HI = 9'h0FF;
   // program control bits
   localparam int CTL_PCLK = 7;
   localparam int CTL_PDN = 5;
   localparam int CTL_ERH = 4;
   localparam int CTL_ERL = 3;
   localparam int CTL_LAT = 1;
   localparam int CTL_PGM = 0;
   // nonvolatile config bits
   localparam int NV_CON_HI = 6;
   localparam int NV_CON_LO = 5;
   localparam int NV_SEC = 4;
   localparam int NV_BP_HI = 3;
   // values
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] NV_FACTORY = 8'h70;
   localparam logic [7:0] SHADOW_RST = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [23:0] PAD_ZERO = 24'h000000;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int REC_TIME_NS = 1000;
   localparam int CNT_W = 16;

   typedef enum logic [1:0] {
      EEPC_PROG = 2'b00,
      EEPC_BYTE_ERASE = 2'b01,
      EEPC_BLK_ERASE = 2'b10,
      EEPC_BULK_ERASE = 2'b11
   } eepc_mode_e;

   function automatic logic [1:0] eepc_blk(input logic [8:0] idx);
      return idx[8:BLK_LSB];
   endfunction
endpackage

// ==== eepc_cells.sv ====
// nonvolatile cell array with the configuration byte
`timescale 1ns/1ps
module eepc_cells (
   // clock
   input wire logic clk,
   // operation request, one pulse per high-voltage turn-on
   input wire logic op_go,
   input wire eepc_pkg::eepc_mode_e op_mode,
   input wire logic op_nv,
   input wire logic [8:0] op_idx,
   input wire logic [7:0] op_data,
   // read side
   input wire logic [8:0] rd_idx,
   output logic [7:0] rd_data,
   output logic [7:0] nv_byte
);
   // cells are nonvolatile: no reset, the array leaves the factory erased, the config byte at NV_FACTORY
   logic [7:0] mem [eepc_pkg::ARR_BYTES] = '{default: eepc_pkg::ERASED_BYTE};
   logic [7:0] nv_reg = eepc_pkg::NV_FACTORY;
   // target byte as it stood before the operation
   logic [7:0] tgt_byte;

   assign tgt_byte = mem[op_idx];
   assign rd_data = mem[rd_idx];
   assign nv_byte = nv_reg;

   always_ff @(posedge clk) begin
      if (op_go) begin
         case (op_mode)
            eepc_pkg::EEPC_PROG: begin
               // programming only clears bits
               if (op_nv) begin
                  nv_reg <= nv_reg & op_data;
               end else begin
                  mem[op_idx] <= mem[op_idx] & op_data;
               end
            end
            eepc_pkg::EEPC_BYTE_ERASE: begin
               if (op_nv) begin
                  nv_reg <= eepc_pkg::ERASED_BYTE;
               end else begin
                  mem[op_idx] <= eepc_pkg::ERASED_BYTE;
               end
            end
            eepc_pkg::EEPC_BLK_ERASE: begin
               // whole block of the target, config byte untouched
               for (int i = 0; i < eepc_pkg::ARR_BYTES; i++) begin
                  if (eepc_pkg::eepc_blk(9'(i)) == eepc_pkg::eepc_blk(op_idx)) begin
                     mem[i] <= eepc_pkg::ERASED_BYTE;
                  end
               end
            end
            default: begin
               for (int i = 0; i < eepc_pkg::ARR_BYTES; i++) begin
                  mem[i] <= eepc_pkg::ERASED_BYTE;
               end
            end
         endcase
      end
   end

   prog_clears_a: assert property (@(posedge clk)
      op_go && op_mode == eepc_pkg::EEPC_PROG && !op_nv
      |=> mem[$past(op_idx)] == ($past(tgt_byte) & $past(op_data)))
      else $error("program set a bit from 0 to 1");
   nv_kept_a: assert property (@(posedge clk)
      op_go && op_mode[1] |=> $stable(nv_reg))
      else $error("block or bulk erase altered the config byte");
endmodule

// ==== eepc_ctrl.sv ====
// eeprom program/erase control with apb register access
// Summary of operation
// - erased reads one; programming only clears bits
// - high voltage only for valid unprotected targets
// - mode field selects program or erase kind
// - latch captures valid array writes, latest wins
// - latched reads return the latched data
// - control writes ignored until array write captured
// - enable refused without latch and capture
// - enable with capture turns on high voltage
// - clearing both bits clears only enable
// - latch cannot clear while enable set
// - mode frozen while enable set
// - block/bulk erase spare the config byte
// - four 128-byte blocks, each own protect bit
// - protected block gets no voltage; bulk blocked
// - config byte copied to shadow on reset/read
// - security blocks range, block/bulk, config byte
// - secured writes invalid, reads normal
// - pump clock select bit, reset clears
// - power down disables array, recovery wait
// - reset clears mode, latch and enable
`timescale 1ns/1ps
module eepc_ctrl #(
   parameter int REC_TIME_NS = eepc_pkg::REC_TIME_NS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // array side effects
   output logic hv_on,
   output logic pump_clk_sel,
   output logic [1:0] mcu_config
);
   // recovery after power-down, least time rounded up
   localparam int REC_CYC_I = (REC_TIME_NS + eepc_pkg::CLK_PERIOD_NS - 1)
      / eepc_pkg::CLK_PERIOD_NS;
   localparam logic [15:0] REC_CYC = 16'(REC_CYC_I);

   if (REC_CYC_I < 1 || REC_CYC_I > 4096) begin : rec_chk
      $error("recovery time out of range");
   end

   function automatic logic in_sec(input logic [8:0] idx);
      return idx >= eepc_pkg::SEC_LO && idx <= eepc_pkg::SEC_HI;
   endfunction

   // registers
   logic pgm_reg;
   logic latch_reg;
   logic cap_reg;
   eepc_pkg::eepc_mode_e mode_reg;
   logic pclk_reg;
   logic pdn_reg;
   logic [15:0] rec_reg;
   logic [8:0] lat_idx_reg;
   logic lat_nv_reg;
   logic [7:0] lat_data_reg;
   logic [7:0] shadow_reg;
   logic load_reg;
   logic hv_reg;
   logic [7:0] prdata_reg;
   logic err_reg;

   // next values
   logic pgm_next;
   logic latch_next;
   logic cap_next;
   eepc_pkg::eepc_mode_e mode_next;
   logic pclk_next;
   logic pdn_next;
   logic [15:0] rec_next;
   logic [7:0] shadow_next;
   logic hv_next;
   logic [7:0] prdata_next;
   logic err_next;

   // cell array read side
   wire [7:0] rd_data;
   wire [7:0] nv_byte;

   // bus decode
   wire setup = psel & ~penable;
   wire acc = psel & penable;
   wire aligned = paddr[1:0] == 2'b00;
   wire is_arr = ~paddr[eepc_pkg::ARR_MSB] & aligned;
   wire is_ctl = paddr == eepc_pkg::CTRL_ADDR;
   wire is_nv = paddr == eepc_pkg::NVCFG_ADDR;
   wire is_sh = paddr == eepc_pkg::SHADOW_ADDR;
   wire mapped = is_arr | is_ctl | is_nv | is_sh;
   wire [8:0] bus_idx = paddr[10:2];

   // array availability
   wire busy = pdn_reg | (rec_reg != 16'h0000);
   wire arr_any = is_arr | is_nv;
   wire refused = arr_any & busy;

   // shadow fields
   wire sec_armed = ~shadow_reg[eepc_pkg::NV_SEC];
   wire [3:0] bp = shadow_reg[eepc_pkg::NV_BP_HI:0];

   // valid target writes; secured bytes and config do not count when armed
   wire valid_tgt = (is_arr & ~(sec_armed & in_sec(bus_idx)))
      | (is_nv & ~sec_armed);
   wire tgt_wr = acc & pwrite & valid_tgt & ~busy;
   wire cap_take = tgt_wr & latch_reg & ~pgm_reg;

   // control register writes
   wire ctl_wr = acc & pwrite & is_ctl;
   wire ctl_lock = latch_reg & ~cap_reg;
   wire ctl_take = ctl_wr & ~ctl_lock;

   wire nv_rd = acc & ~pwrite & is_nv & ~busy;

   // target qualification of the latched operation
   wire blk_prot = bp[eepc_pkg::eepc_blk(lat_idx_reg)];
   logic tgt_ok;

   always_comb begin
      case (mode_reg)
         eepc_pkg::EEPC_PROG,
         eepc_pkg::EEPC_BYTE_ERASE: begin
            if (lat_nv_reg) begin
               tgt_ok = ~sec_armed;
            end else begin
               tgt_ok = ~blk_prot & ~(sec_armed & in_sec(lat_idx_reg));
            end
         end
         eepc_pkg::EEPC_BLK_ERASE: begin
            tgt_ok = ~lat_nv_reg & ~blk_prot & ~sec_armed;
         end
         eepc_pkg::EEPC_BULK_ERASE: begin
            tgt_ok = ~lat_nv_reg & (bp == 4'h0) & ~sec_armed;
         end
         default: begin
            tgt_ok = 1'b0;
         end
      endcase
   end

   // control register next state
   always_comb begin
      pgm_next = pgm_reg;
      latch_next = latch_reg;
      mode_next = mode_reg;
      pclk_next = pclk_reg;
      pdn_next = pdn_reg;
      if (ctl_take) begin
         // enable needs latch set and a captured write
         pgm_next = pwdata[eepc_pkg::CTL_PGM] & latch_reg & cap_reg;
         // latch stays while enable was set, so the voltage can decay
         latch_next = pwdata[eepc_pkg::CTL_LAT] | pgm_reg;
         if (!pgm_reg) begin
            mode_next = eepc_pkg::eepc_mode_e'(pwdata[eepc_pkg::CTL_ERH:eepc_pkg::CTL_ERL]);
         end
         pclk_next = pwdata[eepc_pkg::CTL_PCLK];
         pdn_next = pwdata[eepc_pkg::CTL_PDN];
      end
   end

   // capture is lost when the latch drops
   assign cap_next = latch_next & (cap_reg | cap_take);

   // recovery countdown after power-up
   always_comb begin
      rec_next = rec_reg;
      if (pdn_reg & ~pdn_next) begin
         rec_next = REC_CYC;
      end else if (rec_reg != 16'h0000) begin
         rec_next = rec_reg - 16'h0001;
      end
   end

   // shadow reload at reset release and on config reads
   assign shadow_next = (load_reg | nv_rd) ? nv_byte : shadow_reg;

   // power-down also removes the voltage
   assign hv_next = pgm_reg & latch_reg & cap_reg & tgt_ok & ~pdn_reg;

   // cell array
   wire op_go = hv_next & ~hv_reg;

   eepc_cells u_cells (
      .clk(clk),
      .op_go(op_go),
      .op_mode(mode_reg),
      .op_nv(lat_nv_reg),
      .op_idx(lat_idx_reg),
      .op_data(lat_data_reg),
      .rd_idx(bus_idx),
      .rd_data(rd_data),
      .nv_byte(nv_byte)
   );

   // read data is prepared in the setup phase so pready can stay high
   wire [7:0] ctl_byte = {pclk_reg, 1'b0, pdn_reg, mode_reg, 1'b0, latch_reg, pgm_reg};
   wire lat_rd = latch_reg & cap_reg;
   wire [7:0] arr_byte = lat_rd ? lat_data_reg : rd_data;

   always_comb begin
      prdata_next = prdata_reg;
      err_next = err_reg;
      if (setup) begin
         err_next = ~mapped | refused;
         if (is_ctl) begin
            prdata_next = ctl_byte;
         end else if (is_sh) begin
            prdata_next = shadow_reg;
         end else if (refused) begin
            prdata_next = eepc_pkg::BYTE_ZERO;
         end else if (is_nv) begin
            prdata_next = nv_byte;
         end else if (is_arr) begin
            prdata_next = arr_byte;
         end else begin
            prdata_next = eepc_pkg::BYTE_ZERO;
         end
      end
   end

   // control state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pgm_reg <= 1'b0;
         latch_reg <= 1'b0;
         cap_reg <= 1'b0;
         mode_reg <= eepc_pkg::EEPC_PROG;
         pclk_reg <= 1'b0;
         pdn_reg <= 1'b0;
         rec_reg <= 16'h0000;
      end else begin
         pgm_reg <= pgm_next;
         latch_reg <= latch_next;
         cap_reg <= cap_next;
         mode_reg <= mode_next;
         pclk_reg <= pclk_next;
         pdn_reg <= pdn_next;
         rec_reg <= rec_next;
      end
   end

   // latched target; a later valid write replaces it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lat_idx_reg <= 9'h000;
         lat_nv_reg <= 1'b0;
         lat_data_reg <= eepc_pkg::BYTE_ZERO;
      end else if (cap_take) begin
         lat_idx_reg <= bus_idx;
         lat_nv_reg <= is_nv;
         lat_data_reg <= pwdata[7:0];
      end
   end

   // shadow and high voltage; load_reg pends the copy until reset is released
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shadow_reg <= eepc_pkg::SHADOW_RST;
         load_reg <= 1'b1;
         hv_reg <= 1'b0;
      end else begin
         shadow_reg <= shadow_next;
         load_reg <= 1'b0;
         hv_reg <= hv_next;
      end
   end

   // bus answer registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_reg <= eepc_pkg::BYTE_ZERO;
         err_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         err_reg <= err_next;
      end
   end

   // outputs
   assign pready = 1'b1;
   assign prdata = {eepc_pkg::PAD_ZERO, prdata_reg};
   assign pslverr = err_reg & acc;
   assign hv_on = hv_reg;
   assign pump_clk_sel = pclk_reg;
   assign mcu_config = shadow_reg[eepc_pkg::NV_CON_HI:eepc_pkg::NV_CON_LO];

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence clr_both_s;
      ctl_take && pgm_reg && !pwdata[eepc_pkg::CTL_PGM] && !pwdata[eepc_pkg::CTL_LAT];
   endsequence

   sequence pgm_only_off_s;
      !pgm_reg && latch_reg;
   endsequence

   pgm_needs_latch_a: assert property (pgm_reg |-> latch_reg && cap_reg)
      else $error("enable set without latch and capture");
   clear_both_a: assert property (clr_both_s |=> pgm_only_off_s)
      else $error("double clear did not keep latch");
   latch_hold_a: assert property ($past(pgm_reg) && $past(latch_reg) |-> latch_reg)
      else $error("latch cleared while enable set");
   mode_frozen_a: assert property (pgm_reg && $past(pgm_reg) |-> $stable(mode_reg))
      else $error("mode changed while enable set");
   ctrl_ignore_a: assert property (ctl_wr && latch_reg && !cap_reg
      |=> $stable(latch_reg) && $stable(pgm_reg) && $stable(pdn_reg))
      else $error("control write taken before capture");
   hv_protect_a: assert property (hv_reg && !lat_nv_reg |-> !blk_prot)
      else $error("voltage on a protected block");
   bulk_clear_a: assert property (hv_reg && mode_reg == eepc_pkg::EEPC_BULK_ERASE
      |-> bp == 4'h0 && !sec_armed)
      else $error("bulk erase with protection set");
   secure_hv_a: assert property (hv_reg && sec_armed
      |-> !mode_reg[1] && !lat_nv_reg && !in_sec(lat_idx_reg))
      else $error("voltage on secured target");
   shadow_load_a: assert property (nv_rd |=> shadow_reg == $past(nv_byte))
      else $error("config read did not reload shadow");
   latched_read_a: assert property (setup && !pwrite && is_arr && lat_rd && !busy
      |=> prdata_reg == $past(lat_data_reg))
      else $error("latched read returned array data");
   reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> !pgm_reg && !latch_reg && mode_reg == eepc_pkg::EEPC_PROG && !hv_reg)
      else $error("reset left program state set");
endmodule

// ==== tb_top.sv ====
// self-checking bench for the eeprom program/erase controller
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] CT = eepc_pkg::CTRL_ADDR;
   localparam logic [11:0] NV = eepc_pkg::NVCFG_ADDR;
   localparam logic [11:0] SH = eepc_pkg::SHADOW_ADDR;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, hv_on, pump_clk_sel, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [1:0] mcu_config;
   int n_fail, comparisons, i, a;
   int mem[512];
   int nv, shadow;

   // short recovery of 10 cycles, still long enough that a read right after power-up is refused
   eepc_ctrl #(.REC_TIME_NS(100)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hv_on(hv_on), .pump_clk_sel(pump_clk_sel),
      .mcu_config(mcu_config));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic we, input logic [11:0] ad, input logic [31:0] wd);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= we;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [11:0] ad, input int exp, input logic e);
      apb(1'b0, ad, 32'h0);
      chk(what, 32'(exp), rd);
      chk("pslverr", {31'h0, e}, {31'h0, err});
   endtask

   // full latch / enable / release sequence, model updated only when voltage is allowed
   task automatic op(input int mode, input logic [11:0] ad, input int dat);
      int cv, j, blk, ok;
      cv = mode * 8 + 2;
      j = ad / 4;
      blk = (j < 512) ? j / 128 : 0;
      dat = dat & 'hFF;
      if (ad == NV) ok = shadow[4] == 1 && mode < 2;
      else ok = shadow[blk] == 0 && !(shadow[4] == 0 && mode >= 2)
         && !(mode == 3 && (shadow & 'hF) != 0);
      apb(1'b1, CT, cv);
      apb(1'b1, ad, dat);
      rdchk("latched read", 12'(((j + 1) % 512) * 4), dat, 1'b0);
      apb(1'b1, CT, cv + 1);
      repeat (3) @(posedge clk);
      chk("hv_on", ok, {31'h0, hv_on});
      apb(1'b1, CT, 0);
      rdchk("ctrl after pgm clear", CT, cv, 1'b0);
      chk("hv_on off", 0, {31'h0, hv_on});
      apb(1'b1, CT, 0);
      rdchk("ctrl idle", CT, 0, 1'b0);
      if (ok) begin
         if (ad == NV) nv = (mode == 0) ? nv & dat : 'hFF;
         else if (mode == 0) mem[j] &= dat;
         else for (int m = 0; m < 512; m++)
            if (mode == 3 || (mode == 2 && m / 128 == blk) || m == j) mem[m] = 'hFF;
      end
   endtask

   task automatic sweep();
      for (int j = 0; j < 512; j++) rdchk("array", 12'(j * 4), mem[j], 1'b0);
      rdchk("config byte", NV, nv, 1'b0);
      shadow = nv;
      rdchk("shadow", SH, shadow, 1'b0);
      chk("mcu_config", (shadow >> 5) & 3, {30'h0, mcu_config});
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rst_n = 1'b0;
      seed = 32'h63C4;
      nv = 'h70;
      shadow = 'h70;
      for (i = 0; i < 512; i++) mem[i] = 'hFF;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("hv_on reset", 0, {31'h0, hv_on});
      chk("pump reset", 0, {31'h0, pump_clk_sel});
      rdchk("ctrl reset", CT, 0, 1'b0);
      rdchk("shadow reset", SH, 'h70, 1'b0);
      sweep();
      apb(1'b1, CT, 'h80);
      rdchk("ctrl pump", CT, 'h80, 1'b0);
      chk("pump select", 1, {31'h0, pump_clk_sel});
      apb(1'b1, CT, 0);
      for (i = 0; i < 6; i++) begin
         seed = lfsr_next(seed);
         a = seed[8:0];
         op(0, 12'(a * 4), seed[23:16]);
         op(0, 12'(a * 4), seed[31:24]);
      end
      // interlocks on the control register
      apb(1'b1, CT, 3);
      rdchk("pgm refused", CT, 2, 1'b0);
      apb(1'b1, CT, 'h80);
      rdchk("ctrl ignored", CT, 2, 1'b0);
      apb(1'b1, 12'h100, 'h5A);
      apb(1'b1, 12'h104, 'h3C);
      apb(1'b1, CT, 3);
      apb(1'b1, CT, 1);
      rdchk("latch held", CT, 3, 1'b0);
      apb(1'b1, CT, 'h1B);
      rdchk("mode frozen", CT, 3, 1'b0);
      apb(1'b1, CT, 0);
      apb(1'b1, CT, 0);
      mem[65] &= 'h3C;
      sweep();
      op(1, 12'h104, 0);
      seed = lfsr_next(seed);
      op(2, 12'(seed[8:0] * 4), 0);
      sweep();
      op(3, 12'h3FC, 0);
      sweep();
      // protection through the shadow copy
      op(1, NV, 0);
      sweep();
      op(0, 12'h200, 0);
      op(0, NV, 'hB2);
      sweep();
      op(0, 12'h000, 'h0F);
      op(0, 12'h600, 'h11);
      op(0, 12'h200, 'hA5);
      op(3, 12'h600, 0);
      op(2, 12'h600, 0);
      op(0, 12'h380, 'h33);
      sweep();
      // arm security; it cannot be undone within this run
      op(0, NV, 'hA2);
      sweep();
      op(2, 12'h010, 0);
      apb(1'b1, CT, 'h0A);
      apb(1'b1, NV, 0);
      apb(1'b1, 12'h3D4, 0);
      apb(1'b1, CT, 'h0B);
      rdchk("secured not captured", CT, 'h0A, 1'b0);
      op(1, 12'h000, 0);
      sweep();
      apb(1'b1, CT, 'h20);
      rdchk("powered down", 12'h010, 0, 1'b1);
      apb(1'b1, CT, 0);
      rdchk("recovering", 12'h010, 0, 1'b1);
      repeat (12) @(posedge clk);
      rdchk("recovered", 12'h010, mem[4], 1'b0);
      rdchk("unmapped", 12'hFFC, 0, 1'b1);
      apb(1'b1, SH, 0);
      rdchk("shadow read only", SH, shadow, 1'b0);
      apb(1'b1, CT, 'h9A);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk("ctrl second reset", CT, 0, 1'b0);
      chk("pump second reset", 0, {31'h0, pump_clk_sel});
      finish_test();
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      finish_test();
   end
endmodule
